// ==== core/scd_regs.sv ====
// Purpose: Serial controller DMA buffer B addresses, first-error offsets, event mask
// Assumes: Plain register port; event strobes are one-cycle pulses on ref_clk
// Notes: Pending flags are sticky, cleared by writing one; set beats clear
// Notes on behaviour
// - Transmit B start: 13 writable bits, top 011
// - Transmit B end: 13 writable bits, top 011
// - Read-only first error offset, receive A
// - Read-only first error offset, receive B
// - No error reads offset zero
// - Keep first error, ignore later ones
// - Rearm on buffer reload or DMA reset
// - Mask bits 12..9: buffer unload enables
// - Mask bits 8..5: I2C event enables
// - Mask bit 4 underrun, bit 3 overrun
// - Mask bits 2..0 enables; 15..13 zero
// - Pending flags share enable bit positions
// - Transmit byte counter clears to zero at unload
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_regs (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// Register port
	input  wire logic [`SCD_ADDR_W-1:0] reg_addr,
	input  wire logic [`SCD_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [`SCD_DATA_W-1:0] reg_rdata,
	// Receive DMA error capture
	input  wire logic                   rx_a_err,
	input  wire logic                   rx_b_err,
	input  wire logic [`SCD_OFS_W-1:0]  rx_a_pos,
	input  wire logic [`SCD_OFS_W-1:0]  rx_b_pos,
	input  wire logic                   rx_a_reload,
	input  wire logic                   rx_b_reload,
	input  wire logic                   rx_dma_reset,
	// Transmit DMA
	input  wire logic                   tx_byte_stb,
	input  wire logic                   tx_unload,
	// Events in mask bit order
	input  wire logic [`SCD_EVT_W-1:0]  event_stb,
	// Buffer B addresses to the DMA engine
	output logic      [`SCD_DATA_W-1:0] tx_b_start_addr,
	output logic      [`SCD_DATA_W-1:0] tx_b_end_addr,
	// Interrupt
	output logic                        irq
);
	scd_pkg::scd_top_state_t s_q;
	scd_pkg::scd_top_state_t s_d;
	scd_pkg::scd_ofs_t       tx_count;

	scd_cap_if cap_a ();
	scd_cap_if cap_b ();

	// Reload and DMA reset both clear the captured offset
	assign cap_a.err   = rx_a_err;
	assign cap_a.pos   = rx_a_pos;
	assign cap_a.rearm = rx_a_reload | rx_dma_reset;
	assign cap_b.err   = rx_b_err;
	assign cap_b.pos   = rx_b_pos;
	assign cap_b.rearm = rx_b_reload | rx_dma_reset;

	scd_err_capture u_cap_a (
		.ref_clk (ref_clk),
		.rst     (rst),
		.cap     (cap_a.cap)
	);

	scd_err_capture u_cap_b (
		.ref_clk (ref_clk),
		.rst     (rst),
		.cap     (cap_b.cap)
	);

	scd_tx_counter u_tx_cnt (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.byte_stb (tx_byte_stb),
		.unload   (tx_unload),
		.count    (tx_count)
	);

	function automatic logic [`SCD_DATA_W-1:0] addr_word(input scd_pkg::scd_ofs_t a);
		addr_word = {`SCD_ADDR_TOP, a};
	endfunction

	function automatic logic [`SCD_DATA_W-1:0] zext(input scd_pkg::scd_ofs_t v);
		zext = {`SCD_RO_TOP, v};
	endfunction

	always_comb begin
		s_d       = s_q;
		s_d.rdata = `SCD_DATA_ZERO;
		if (reg_wr) begin
			case (reg_addr)
				`SCD_OFF_TX_B_START: s_d.tx_b_start = reg_wdata[`SCD_OFS_W-1:0];
				`SCD_OFF_TX_B_END:   s_d.tx_b_end   = reg_wdata[`SCD_OFS_W-1:0];
				// Enables in bits 12..0, bits above are dropped
				`SCD_OFF_IRQ_MASK:   s_d.mask = reg_wdata[`SCD_EVT_W-1:0];
				`SCD_OFF_PENDING:    s_d.pend = s_q.pend & ~reg_wdata[`SCD_EVT_W-1:0];
				default: ;
			endcase
		end
		// Set after clear so an event in the clear cycle is kept
		s_d.pend = s_d.pend | event_stb;
		if (reg_rd) begin
			case (reg_addr)
				`SCD_OFF_TX_B_START: s_d.rdata = addr_word(s_q.tx_b_start);
				`SCD_OFF_TX_B_END:   s_d.rdata = addr_word(s_q.tx_b_end);
				`SCD_OFF_RX_A_ERR:   s_d.rdata = zext(cap_a.ofs);
				`SCD_OFF_RX_B_ERR:   s_d.rdata = zext(cap_b.ofs);
				`SCD_OFF_TX_COUNT:   s_d.rdata = zext(tx_count);
				`SCD_OFF_IRQ_MASK:   s_d.rdata = zext(s_q.mask);
				`SCD_OFF_PENDING:    s_d.rdata = zext(s_q.pend);
				default:             s_d.rdata = `SCD_DATA_ZERO;
			endcase
		end
		// Registered from the next flags, so irq changes in the same cycle as the pending flag
		s_d.irq = |(s_d.pend & s_d.mask);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q.tx_b_start <= `SCD_OFS_ZERO;
			s_q.tx_b_end   <= `SCD_OFS_ZERO;
			s_q.mask       <= `SCD_EVT_ZERO;
			s_q.pend       <= `SCD_EVT_ZERO;
			s_q.rdata      <= `SCD_DATA_ZERO;
			s_q.irq        <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Top bits are fixed wiring; the low bits come straight from the state register
	assign reg_rdata       = s_q.rdata;
	assign irq             = s_q.irq;
	assign tx_b_start_addr = addr_word(s_q.tx_b_start);
	assign tx_b_end_addr   = addr_word(s_q.tx_b_end);
endmodule

// ==== shared/scd_defs.svh ====
// Purpose: Offsets, field positions, reset values and widths for the serial DMA register block
// Assumes: 16-bit register words, byte addresses as printed
// Notes: Definitions only
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

`define SCD_ADDR_W         16
`define SCD_DATA_W         16
`define SCD_OFS_W          13
`define SCD_EVT_W          13
`define SCD_OFF_TX_B_START 16'h440c
`define SCD_OFF_TX_B_END   16'h440e
`define SCD_OFF_RX_A_ERR   16'h441a
`define SCD_OFF_RX_B_ERR   16'h441c
`define SCD_OFF_TX_COUNT   16'h4414
`define SCD_OFF_PENDING    16'h460e
`define SCD_OFF_IRQ_MASK   16'h4626
`define SCD_ADDR_TOP       3'h3
`define SCD_RO_TOP         3'h0
`define SCD_OFS_ZERO       13'h0000
`define SCD_OFS_ONE        13'h0001
`define SCD_EVT_ZERO       13'h0000
`define SCD_DATA_ZERO      16'h0000

`define SCD_EV_TX_B_UNLD   12
`define SCD_EV_TX_A_UNLD   11
`define SCD_EV_RX_B_UNLD   10
`define SCD_EV_RX_A_UNLD   9
`define SCD_EV_NACK        8
`define SCD_EV_CMD_DONE    7
`define SCD_EV_TX_DONE     6
`define SCD_EV_RX_DONE     5
`define SCD_EV_TX_UNDER    4
`define SCD_EV_RX_OVER     3
`define SCD_EV_TX_IDLE     2
`define SCD_EV_TX_FREE     1
`define SCD_EV_RX_DATA     0

`endif

// ==== shared/scd_pkg.sv ====
// Purpose: Types shared by the serial DMA register block
// Assumes: scd_defs.svh supplies widths
// Notes: Types only
`include "scd_defs.svh"
package scd_pkg;
	typedef logic [`SCD_OFS_W-1:0] scd_ofs_t;
	typedef logic [`SCD_EVT_W-1:0] scd_evt_t;
	typedef enum logic [1:0] {SCD_ARMED, SCD_HELD} scd_cap_st_t;
	typedef struct packed {
		scd_cap_st_t st;
		scd_ofs_t    ofs;
	} scd_cap_state_t;
	typedef struct packed {
		scd_ofs_t cnt;
	} scd_cnt_state_t;
	typedef struct packed {
		scd_ofs_t tx_b_start;
		scd_ofs_t tx_b_end;
		scd_evt_t mask;
		scd_evt_t pend;
		logic [`SCD_DATA_W-1:0] rdata;
		logic                   irq;
	} scd_top_state_t;
endpackage

// ==== shared/scd_cap_if.sv ====
// Purpose: Carrier between the top and one first-error capture unit
// Assumes: Single clock domain
// Notes: Error offset is the receive position at the error byte
`timescale 1ns/10ps
interface scd_cap_if;
	logic             err;
	logic             rearm;
	scd_pkg::scd_ofs_t pos;
	scd_pkg::scd_ofs_t ofs;
	modport top (output err, output rearm, output pos, input ofs);
	modport cap (input err, input rearm, input pos, output ofs);
endinterface

// ==== core/scd_err_capture.sv ====
// Purpose: Holds the offset of the first receive error in one buffer
// Assumes: Error, rearm and position come from same-clock logic
// Notes: Rearm wins over an error in the same cycle
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_err_capture (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Capture link
	scd_cap_if.cap   cap
);
	scd_pkg::scd_cap_state_t s_q;
	scd_pkg::scd_cap_state_t s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.st)
			scd_pkg::SCD_ARMED: begin
				if (cap.err && !cap.rearm) begin
					s_d.ofs = cap.pos;
					s_d.st  = scd_pkg::SCD_HELD;
				end
			end
			scd_pkg::SCD_HELD: begin
				// Later errors are ignored here
			end
			default: s_d.st = scd_pkg::SCD_ARMED;
		endcase
		if (cap.rearm) begin
			// Reload or DMA reset clears and arms
			s_d.st  = scd_pkg::SCD_ARMED;
			s_d.ofs = `SCD_OFS_ZERO;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q.st  <= scd_pkg::SCD_ARMED;
			s_q.ofs <= `SCD_OFS_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	assign cap.ofs = s_q.ofs;
endmodule

// ==== core/scd_tx_counter.sv ====
// Purpose: Byte counter into the active transmit buffer
// Assumes: Byte and unload strobes come from the DMA engine, same clock
// Notes: Unload beats a byte strobe in the same cycle
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_tx_counter (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// DMA strobes
	input  wire logic              byte_stb,
	input  wire logic              unload,
	// Count
	output scd_pkg::scd_ofs_t      count
);
	scd_pkg::scd_cnt_state_t s_q;
	scd_pkg::scd_cnt_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (unload) begin
			s_d.cnt = `SCD_OFS_ZERO;
		end else if (byte_stb) begin
			s_d.cnt = s_q.cnt + `SCD_OFS_ONE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q.cnt <= `SCD_OFS_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;
endmodule

// ==== testbench/scd_dma_model.sv ====
// Purpose: DMA engine side of the register block
// Assumes: One-cycle strobes
// Notes: Position is inverted when idle, so a stale value cannot pass
`timescale 1ns/10ps
module scd_dma_model (
	// Clock
	input  wire logic        ref_clk,
	// DMA strobes and events
	output logic      [6:0]  stb,
	output logic      [12:0] pos,
	output logic      [12:0] evt
);
	initial begin
		stb = '0;
		pos = 13'h1555;
		evt = '0;
	end
	task fire(input int k, input logic [12:0] p);
		@(posedge ref_clk);
		stb[k] <= 1'b1;
		pos    <= p;
		@(posedge ref_clk);
		stb <= '0;
		pos <= ~p;
	endtask
	task raise(input logic [12:0] m);
		@(posedge ref_clk);
		evt <= m;
		@(posedge ref_clk);
		evt <= '0;
	endtask
endmodule

// ==== testbench/scd_regs_sva.sv ====
// Purpose: Port checks of the register block
// Assumes: irq follows its cause by one cycle
// Notes: Bound from the bench
`timescale 1ns/10ps
module scd_regs_sva (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Events and outputs
	input wire logic [12:0] event_stb,
	input wire logic [15:0] tx_b_start_addr,
	input wire logic [15:0] tx_b_end_addr,
	input wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	start_write_a: assert property (reg_wr && reg_addr == 16'h440c |=>
		tx_b_start_addr == {3'h3, $past(reg_wdata[12:0])}) else $error("start addr");
	end_write_a: assert property (reg_wr && reg_addr == 16'h440e |=>
		tx_b_end_addr == {3'h3, $past(reg_wdata[12:0])}) else $error("end addr");
	start_top_a: assert property (tx_b_start_addr[15:13] == 3'h3) else $error("start top");
	end_top_a: assert property (tx_b_end_addr[15:13] == 3'h3) else $error("end top");
	mask_top_a: assert property (reg_rd && reg_addr == 16'h4626 |=>
		reg_rdata[15:13] == 3'h0) else $error("mask top");
	err_top_a: assert property (reg_rd && reg_addr[15:4] == 12'h441 |=>
		reg_rdata[15:13] == 3'h0) else $error("offset top");
	irq_rise_a: assert property ($rose(irq) |->
		$past(event_stb) != 13'h0 || $past(reg_wr)) else $error("irq cause");
	irq_off_a: assert property (reg_wr && reg_addr == 16'h4626 && reg_wdata[12:0] == 13'h0
		|=> !irq) else $error("irq masked");
	cover property ($rose(irq));
	cover property (reg_wr && reg_addr == 16'h440c);
	cover property (reg_rd && reg_addr == 16'h441a);
endmodule

// ==== testbench/scd_regs_tb.sv ====
// Purpose: Self-checking bench of the register block
// Assumes: Inputs change by nonblocking assignment after rising edges
// Notes: Under two hundred cycles
`timescale 1ns/10ps
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module scd_regs_tb;
	logic        ref_clk, rst, reg_wr, reg_rd, irq;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, tx_start, tx_end, v;
	logic [6:0]  stb;
	logic [12:0] pos, evt;
	int          num_errors, comparisons;
	scd_regs u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_a_err(stb[0]),
		.rx_b_err(stb[1]), .rx_a_pos(pos), .rx_b_pos(pos), .rx_a_reload(stb[2]),
		.rx_b_reload(stb[3]), .rx_dma_reset(stb[4]), .tx_byte_stb(stb[5]),
		.tx_unload(stb[6]), .event_stb(evt), .tx_b_start_addr(tx_start),
		.tx_b_end_addr(tx_end), .irq(irq));
	scd_dma_model u_dma (.ref_clk(ref_clk), .stb(stb), .pos(pos), .evt(evt));
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task t_addr;
		wr(16'h440c, 16'hffff);
		wr(16'h440e, 16'h0a55);
		rd(16'h440c);
		`CK(v, 16'h7fff)
		`CK(tx_end, 16'h6a55)
		rd(16'h4500);
		`CK(v, 16'h0000)
		$display("address test done");
	endtask
	task t_err;
		rd(16'h441a);
		`CK(v, 16'h0000)
		u_dma.fire(0, 13'h0005);
		u_dma.fire(0, 13'h0009);
		wr(16'h441a, 16'h1fff);
		rd(16'h441a);
		`CK(v, 16'h0005)
		u_dma.fire(2, 13'h0000);
		rd(16'h441a);
		`CK(v, 16'h0000)
		u_dma.fire(0, 13'h0007);
		rd(16'h441a);
		`CK(v, 16'h0007)
		u_dma.fire(1, 13'h1abc);
		rd(16'h441c);
		`CK(v, 16'h1abc)
		u_dma.fire(4, 13'h0000);
		rd(16'h441c);
		`CK(v, 16'h0000)
		rd(16'h441a);
		`CK(v, 16'h0000)
		$display("error offset test done");
	endtask
	task t_cnt;
		repeat (3) u_dma.fire(5, 13'h0000);
		rd(16'h4414);
		`CK(v, 16'h0003)
		u_dma.fire(6, 13'h0000);
		rd(16'h4414);
		`CK(v, 16'h0000)
		$display("counter test done");
	endtask
	task t_irq;
		wr(16'h4626, 16'h0000);
		u_dma.raise(13'h1fff);
		#1 `CK(irq, 1'b0)
		rd(16'h460e);
		`CK(v, 16'h1fff)
		wr(16'h460e, 16'h1fff);
		for (int i = 0; i < 13; i++) begin
			wr(16'h4626, 16'he000 | (16'h0001 << i));
			rd(16'h4626);
			`CK(v, 16'h0001 << i)
			u_dma.raise(13'h0001 << i);
			#1 `CK(irq, 1'b1)
			wr(16'h460e, 16'h0001 << i);
			#1 `CK(irq, 1'b0)
		end
		$display("interrupt test done");
	endtask
	task t_rst;
		u_dma.raise(13'h1fff);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CK(irq, 1'b0)
		`CK(tx_start, 16'h6000)
		rd(16'h460e);
		`CK(v, 16'h0000)
		rd(16'h4626);
		`CK(v, 16'h0000)
		$display("reset test done");
	endtask
	task summarize;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 16'h0000;
		reg_wdata = 16'h0000;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		#1 `CK(tx_start, 16'h6000)
		t_addr;
		t_err;
		t_cnt;
		t_irq;
		t_rst;
		summarize;
	end
	initial begin
		#50000;
		num_errors++;
		summarize;
	end
endmodule
bind scd_regs scd_regs_sva u_sva (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.event_stb(event_stb), .tx_b_start_addr(tx_b_start_addr),
	.tx_b_end_addr(tx_b_end_addr), .irq(irq));
